// ### design/fsk_decoder_defines.svh
// Purpose: Offsets, field positions and reset values of the FSK decoder back end.
// Assumes: 8-bit register port, one register per address.
// Notes: Included by its bare name.
`ifndef FSK_DECODER_DEFINES_SVH
`define FSK_DECODER_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 8
`define CTRL_ADDR 8'h00
`define STAT_ADDR 8'h01
`define BYTE_ADDR 8'h02

`define CTRL_PWDN_BIT 0
`define CTRL_RING_IRQ_MASK_BIT 1
`define CTRL_CARRIER_IRQ_MASK_BIT 2
`define CTRL_BMSK_BIT 3
`define CTRL_SEL_BIT 4
`define CTRL_EDGE_EN_BIT 5
`define CTRL_W 6
`define CTRL_RESET 6'h0f

`define STAT_RING_BIT 0
`define STAT_CAR_BIT 1
`define STAT_BYTE_BIT 2
`define STAT_EDGE_BIT 3
`define STAT_RAW_BIT 4
`define STAT_COOK_BIT 5
`define FLAG_W 4

`define CHAR_LAST 4'h9
`define BYTE_RESET 8'h00

`endif

// ### design/fsk_decoder_pkg.sv
// Purpose: Types shared by the FSK decoder back end.
// Assumes: Nothing beyond the defines header.
// Notes: Framer states are one-hot.
`default_nettype none
package fsk_decoder_pkg;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b01,
    FR_SHIFT = 2'b10
  } frame_state_t;

endpackage : fsk_decoder_pkg
`default_nettype wire

// ### design/fsk_serial_packet_decoder.sv
// Purpose: Serial outputs, byte framer and event flags of a caller-ID FSK decoder.
// Assumes: Front-end inputs are synchronous to mclk_in; bit_strobe_in marks each bit centre.
// Notes: Registers at 0x00 control, 0x01 status, 0x02 framed byte.
//
// Contract
// - Carrier detect sets carrier flag unless powered down; interrupt if mask zero and enabled.
// - Raw serial bit carries the whole demodulated stream including seizure.
// - Cleaned serial bit follows raw but leaves out the seizure pattern.
// - With no FSK data present both serial bits are held high.
// - Framer drops first and tenth bit of a character, keeps eight.
// - Valid byte is stored, byte flag set; interrupt if mask zero.
// - Framer input is raw or cleaned stream by the source select bit.
// - A character starts only on a zero start bit.
// - With source select one, seizure bits are never framed.
// - Ring detection keeps working while the decoder is powered down.
// - Each falling edge of the raw bit is an interrupt source.
// - A source whose flag is still set raises no further interrupt.
// - Raw-edge enable disables ring, carrier and byte interrupts.
// - Ring flag sets on each falling edge of the ring detect signal.
`timescale 1ns/1ns
`default_nettype none
`include "fsk_decoder_defines.svh"

module fsk_serial_packet_decoder (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [`ADDR_W-1:0] reg_addr_in,
  input wire logic [`DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`DATA_W-1:0] reg_rdata_out,
  input wire logic demod_bit_in,
  input wire logic fsk_present_in,
  input wire logic seizure_in,
  input wire logic carrier_in,
  input wire logic bit_strobe_in,
  input wire logic ring_detect_signal_in,
  input wire logic peri_irq_enable_in,
  output logic raw_serial_bit_out,
  output logic cleaned_serial_bit_out,
  output logic peri_irq_req_out
);
  import fsk_decoder_pkg::*;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  logic [`CTRL_W-1:0] ctrl_ff;
  logic [`CTRL_W-1:0] nxt_ctrl;
  logic [`FLAG_W-1:0] flags_ff;
  logic [`FLAG_W-1:0] nxt_flags;
  logic [`DATA_W-1:0] framed_byte_reg_ff;
  logic [`DATA_W-1:0] nxt_framed_byte_reg;
  logic [`DATA_W-1:0] rdata_ff;
  logic [`DATA_W-1:0] nxt_rdata;
  wire ctrl_wr = reg_wr_in && (reg_addr_in == `CTRL_ADDR);
  wire stat_wr = reg_wr_in && (reg_addr_in == `STAT_ADDR);
  wire decoder_power_down = ctrl_ff[`CTRL_PWDN_BIT];
  wire ring_irq_mask = ctrl_ff[`CTRL_RING_IRQ_MASK_BIT];
  wire carrier_irq_mask = ctrl_ff[`CTRL_CARRIER_IRQ_MASK_BIT];
  wire byte_irq_mask = ctrl_ff[`CTRL_BMSK_BIT];
  wire frame_source_select = ctrl_ff[`CTRL_SEL_BIT];
  wire raw_edge_irq_enable = ctrl_ff[`CTRL_EDGE_EN_BIT];

  // ----------------------------------------------------------------
  // Serial outputs
  // ----------------------------------------------------------------
  logic raw_ff;
  logic cook_ff;
  logic nxt_raw;
  logic nxt_cook;
  wire no_data = decoder_power_down || !fsk_present_in;
  assign nxt_raw = no_data ? 1'b1 : demod_bit_in;
  assign nxt_cook = (no_data || seizure_in) ? 1'b1 : demod_bit_in;
  assign raw_serial_bit_out = raw_ff;
  assign cleaned_serial_bit_out = cook_ff;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      raw_ff <= 1'b1;
      cook_ff <= 1'b1;
    end else begin
      raw_ff <= nxt_raw;
      cook_ff <= nxt_cook;
    end
  end

  // ----------------------------------------------------------------
  // Byte framer
  // ----------------------------------------------------------------
  frame_state_t state_ff;
  frame_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [`DATA_W-1:0] shift_ff;
  logic [`DATA_W-1:0] nxt_shift;
  logic byte_done;
  wire frame_bit = frame_source_select ? nxt_cook : nxt_raw;
  wire seizure_block = frame_source_select && seizure_in;
  wire sample = bit_strobe_in && !decoder_power_down;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    byte_done = 1'b0;
    case (state_ff)
      FR_IDLE: begin
        if (sample && !frame_bit && !seizure_block) begin
          nxt_state = FR_SHIFT;
          nxt_cnt = 4'h1;
        end
      end
      FR_SHIFT: begin
        if (decoder_power_down || seizure_block) begin
          nxt_state = FR_IDLE;
        end else if (sample) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == `CHAR_LAST) begin
            nxt_state = FR_IDLE;
            byte_done = 1'b1;
          end else begin
            nxt_shift = {frame_bit, shift_ff[`DATA_W-1:1]};
          end
        end
      end
      default: begin
        nxt_state = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff <= FR_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= `BYTE_RESET;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // ----------------------------------------------------------------
  // Events, flags and interrupt request
  // ----------------------------------------------------------------
  logic ring_d_ff;
  logic car_d_ff;
  logic irq_ff;
  logic [`FLAG_W-1:0] ev;
  logic [`FLAG_W-1:0] clr;
  logic [`FLAG_W-1:0] fresh;
  logic nxt_irq;
  assign ev[`STAT_RING_BIT] = ring_d_ff && !ring_detect_signal_in;
  assign ev[`STAT_CAR_BIT] = carrier_in && !car_d_ff && !decoder_power_down;
  assign ev[`STAT_BYTE_BIT] = byte_done;
  assign ev[`STAT_EDGE_BIT] = raw_ff && !nxt_raw;
  assign clr = stat_wr ? ~reg_wdata_in[`FLAG_W-1:0] : {`FLAG_W{1'b0}};
  assign fresh = ev & ~flags_ff;
  assign nxt_flags = (flags_ff & ~clr) | ev;
  assign nxt_irq = peri_irq_enable_in && (raw_edge_irq_enable ? fresh[`STAT_EDGE_BIT]
    : ((fresh[`STAT_RING_BIT] && !ring_irq_mask) || (fresh[`STAT_CAR_BIT] && !carrier_irq_mask)
    || (fresh[`STAT_BYTE_BIT] && !byte_irq_mask)));
  assign nxt_ctrl = ctrl_wr ? reg_wdata_in[`CTRL_W-1:0] : ctrl_ff;
  assign nxt_framed_byte_reg = byte_done ? shift_ff : framed_byte_reg_ff;
  assign peri_irq_req_out = irq_ff;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ring_d_ff <= 1'b1;
      car_d_ff <= 1'b0;
      flags_ff <= {`FLAG_W{1'b0}};
      irq_ff <= 1'b0;
      ctrl_ff <= `CTRL_RESET;
      framed_byte_reg_ff <= `BYTE_RESET;
    end else begin
      ring_d_ff <= ring_detect_signal_in;
      car_d_ff <= carrier_in;
      flags_ff <= nxt_flags;
      irq_ff <= nxt_irq;
      ctrl_ff <= nxt_ctrl;
      framed_byte_reg_ff <= nxt_framed_byte_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [`DATA_W-1:0] ctrl_rd = {2'b00, ctrl_ff};
  wire [`DATA_W-1:0] stat_rd = {2'b00, cook_ff, raw_ff, flags_ff};
  assign nxt_rdata = !reg_rd_in ? `BYTE_RESET
    : (reg_addr_in == `CTRL_ADDR) ? ctrl_rd
    : (reg_addr_in == `STAT_ADDR) ? stat_rd
    : (reg_addr_in == `BYTE_ADDR) ? framed_byte_reg_ff
    : `BYTE_RESET;
  assign reg_rdata_out = rdata_ff;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_ff <= `BYTE_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_pwdn_holds_high:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $past(decoder_power_down) |-> raw_serial_bit_out && cleaned_serial_bit_out)
    else $error("Serial bits not high while powered down.");

  chk_raw_follows:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!decoder_power_down && fsk_present_in) |=> raw_serial_bit_out == $past(demod_bit_in))
    else $error("Raw bit does not follow demodulated stream.");

  chk_cook_no_seizure:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    seizure_in |=> cleaned_serial_bit_out)
    else $error("Cleaned bit shows seizure pattern.");

  chk_carrier_flag_set:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (carrier_in && !car_d_ff && !decoder_power_down) |=> flags_ff[`STAT_CAR_BIT])
    else $error("Carrier flag not set on carrier detect.");

  chk_ring_in_pwdn:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (decoder_power_down && ring_d_ff && !ring_detect_signal_in)
    |=> flags_ff[`STAT_RING_BIT])
    else $error("Ring flag lost while powered down.");

  chk_byte_store:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    byte_done |=> framed_byte_reg_ff == $past(shift_ff) && flags_ff[`STAT_BYTE_BIT])
    else $error("Framed byte not stored with flag.");

  chk_byte_hold:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !byte_done |=> $stable(framed_byte_reg_ff))
    else $error("Framed byte changed without a new byte.");

  chk_start_zero:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (state_ff == FR_IDLE && frame_bit) |=> state_ff == FR_IDLE)
    else $error("Framer started on a mark bit.");

  chk_edge_flag:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $fell(raw_serial_bit_out) |-> flags_ff[`STAT_EDGE_BIT])
    else $error("Raw falling edge did not set its flag.");

  chk_edge_excl:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (raw_edge_irq_enable && !ev[`STAT_EDGE_BIT]) |=> !peri_irq_req_out)
    else $error("Other source interrupted while raw-edge enabled.");

  chk_flag_suppress:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (&flags_ff) |=> !peri_irq_req_out)
    else $error("Interrupt raised while every flag was set.");

  chk_cook_follows:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!decoder_power_down && fsk_present_in && !seizure_in)
    |=> cleaned_serial_bit_out == $past(demod_bit_in))
    else $error("Cleaned bit does not follow demodulated stream.");

  chk_absent_high:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !fsk_present_in |=> raw_serial_bit_out && cleaned_serial_bit_out)
    else $error("Serial bits not high without FSK data.");

  chk_ring_flag_set:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (ring_d_ff && !ring_detect_signal_in) |=> flags_ff[`STAT_RING_BIT])
    else $error("Ring flag not set on ring detect falling edge.");

  chk_edge_irq:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (peri_irq_enable_in && raw_edge_irq_enable && ev[`STAT_EDGE_BIT]
    && !flags_ff[`STAT_EDGE_BIT]) |=> peri_irq_req_out)
    else $error("Raw falling edge did not interrupt.");

  chk_irq_needs_enable:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !peri_irq_enable_in |=> !peri_irq_req_out)
    else $error("Interrupt raised while peripheral interrupts disabled.");

  chk_byte_irq:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (peri_irq_enable_in && !raw_edge_irq_enable && !byte_irq_mask && byte_done
    && !flags_ff[`STAT_BYTE_BIT]) |=> peri_irq_req_out)
    else $error("Unmasked framed byte did not interrupt.");

  chk_carrier_irq:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (peri_irq_enable_in && !raw_edge_irq_enable && !carrier_irq_mask && ev[`STAT_CAR_BIT]
    && !flags_ff[`STAT_CAR_BIT]) |=> peri_irq_req_out)
    else $error("Unmasked carrier detect did not interrupt.");

  chk_ring_irq:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (peri_irq_enable_in && !raw_edge_irq_enable && !ring_irq_mask && ev[`STAT_RING_BIT]
    && !flags_ff[`STAT_RING_BIT]) |=> peri_irq_req_out)
    else $error("Unmasked ring detect did not interrupt.");

  chk_masked_quiet:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!raw_edge_irq_enable && ring_irq_mask && carrier_irq_mask && byte_irq_mask)
    |=> !peri_irq_req_out)
    else $error("Interrupt raised while every source was masked.");

  chk_pwdn_idle:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    decoder_power_down |=> state_ff == FR_IDLE)
    else $error("Framer active while powered down.");

  chk_seize_no_byte:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (frame_source_select && seizure_in) |-> !byte_done)
    else $error("Seizure bits framed into a byte.");

  chk_pwdn_no_byte:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    decoder_power_down |-> !byte_done)
    else $error("Byte framed while powered down.");

  chk_flag_sticky:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !stat_wr |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("Event flag cleared without a status write.");

  chk_cnt_range:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    state_ff == FR_SHIFT
    |-> cnt_ff >= 4'h1 && cnt_ff <= `CHAR_LAST)
    else $error("Framer bit count out of range.");

  chk_read_idle:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !reg_rd_in |=> reg_rdata_out == `BYTE_RESET)
    else $error("Read data present without a read strobe.");

endmodule : fsk_serial_packet_decoder
`default_nettype wire

// ### verification/fsk_front_model.sv
// Purpose: Model of the line front end that feeds demodulated bits to the decoder.
// Assumes: Tasks are called from the bench and change lines just after a rising edge.
// Notes: With no FSK present the data line carries no steady value.
`timescale 1ns/1ns
`default_nettype none

module fsk_front_model (
  input wire logic mclk_in,
  output logic demod_bit_out,
  output logic present_out,
  output logic seizure_out,
  output logic carrier_out,
  output logic strobe_out
);
  // ----------------------------------------
  // Line driver
  // ----------------------------------------
  logic bit_ff = 1'b1;
  logic tog_ff = 1'b0;
  initial begin
    present_out = 1'b0;
    seizure_out = 1'b0;
    carrier_out = 1'b0;
    strobe_out = 1'b0;
  end
  always @(posedge mclk_in) tog_ff <= ~tog_ff;
  assign demod_bit_out = present_out ? bit_ff : tog_ff;

  task automatic set_line(input logic p, input logic s, input logic b);
    @(posedge mclk_in);
    present_out <= p;
    seizure_out <= s;
    bit_ff <= b;
  endtask : set_line

  task automatic set_carrier(input logic c);
    @(posedge mclk_in);
    carrier_out <= c;
  endtask : set_carrier

  // Sends one character, element 0 first, with a strobe in the middle of each bit.
  task automatic send_char(input logic [9:0] ch, input logic s);
    for (int i = 0; i < 10; i++) begin
      set_line(1'b1, s, ch[i]);
      @(posedge mclk_in) strobe_out <= 1'b1;
      @(posedge mclk_in) strobe_out <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
  endtask : send_char
endmodule : fsk_front_model
`default_nettype wire

// ### verification/fsk_serial_packet_decoder_test.sv
// Purpose: Self-checking bench for the FSK decoder back end.
// Assumes: Register map and reset values of the defines header.
// Notes: Interrupt pulses are counted and compared as deltas.
`timescale 1ns/1ns
`default_nettype none
`include "fsk_decoder_defines.svh"

module fsk_serial_packet_decoder_test;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  typedef struct packed {logic pd; logic p; logic s; logic b; logic [1:0] q;} row_t;
  localparam row_t ROWS [5] = '{'{1'b1, 1'b1, 1'b0, 1'b0, 2'b11},
    '{1'b0, 1'b0, 1'b0, 1'b0, 2'b11}, '{1'b0, 1'b1, 1'b0, 1'b0, 2'b00},
    '{1'b0, 1'b1, 1'b1, 1'b0, 2'b01}, '{1'b0, 1'b1, 1'b0, 1'b1, 2'b11}};
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic ring_detect_signal_in = 1'b1;
  logic peri_irq_enable_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] irqs = 8'h00;
  logic [7:0] n = 8'h00;
  logic [7:0] d;
  wire logic [7:0] reg_rdata_out;
  wire logic raw_serial_bit_out, cleaned_serial_bit_out, peri_irq_req_out;
  wire logic demod_bit_in, fsk_present_in, seizure_in, carrier_in, bit_strobe_in;
  int failures = 0;
  int n_compared = 0;

  fsk_serial_packet_decoder i_dut (.mclk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .demod_bit_in, .fsk_present_in, .seizure_in,
    .carrier_in, .bit_strobe_in, .ring_detect_signal_in, .peri_irq_enable_in,
    .raw_serial_bit_out, .cleaned_serial_bit_out, .peri_irq_req_out);
  fsk_front_model fe (.mclk_in(mclk_in), .demod_bit_out(demod_bit_in),
    .present_out(fsk_present_in), .seizure_out(seizure_in), .carrier_out(carrier_in),
    .strobe_out(bit_strobe_in));

  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (peri_irq_req_out === 1'b1) irqs <= irqs + 8'h01;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in) {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, v};
    @(posedge mclk_in) reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_in) {reg_rd_in, reg_addr_in} <= {1'b1, a};
    @(posedge mclk_in) reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd

  // Interrupt pulses seen since the previous call.
  function automatic logic [7:0] took();
    took = irqs - n;
    n = irqs;
  endfunction : took

  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(`CTRL_ADDR, d); check(d, 8'h0f);
    rd(`STAT_ADDR, d); check(d, 8'h30);
    rd(`BYTE_ADDR, d); check(d, 8'h00);
    rd(8'h07, d); check(d, 8'h00);
    foreach (ROWS[i]) begin
      wr(`CTRL_ADDR, {7'h07, ROWS[i].pd});
      fe.set_line(ROWS[i].p, ROWS[i].s, ROWS[i].b);
      repeat (2) @(posedge mclk_in);
      #1 check({6'h00, raw_serial_bit_out, cleaned_serial_bit_out}, {6'h00, ROWS[i].q});
    end
    @(posedge mclk_in) peri_irq_enable_in <= 1'b1;
    wr(`STAT_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h00);
    n = irqs;
    fe.send_char({1'b1, 8'ha5, 1'b0}, 1'b0);
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h01);
    rd(`BYTE_ADDR, d); check(d, 8'ha5);
    rd(`BYTE_ADDR, d); check(d, 8'ha5);
    rd(`STAT_ADDR, d); check(d & 8'h04, 8'h04);
    fe.send_char({1'b1, 8'h3c, 1'b0}, 1'b0);
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h00);
    rd(`BYTE_ADDR, d); check(d, 8'h3c);
    wr(`STAT_ADDR, 8'h00);
    rd(`STAT_ADDR, d); check(d & 8'h0f, 8'h00);
    fe.send_char(10'h3ff, 1'b0);
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h00);
    fe.send_char(10'h2aa, 1'b1);
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h01);
    rd(`BYTE_ADDR, d); check(d, 8'h55);
    wr(`STAT_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h10);
    fe.send_char(10'h2aa, 1'b1);
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h00);
    wr(`CTRL_ADDR, 8'h00);
    fe.set_carrier(1'b1);
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h01);
    rd(`STAT_ADDR, d); check(d & 8'h02, 8'h02);
    wr(`CTRL_ADDR, 8'h01);
    n = irqs;
    @(posedge mclk_in) ring_detect_signal_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h01);
    rd(`STAT_ADDR, d); check(d & 8'h01, 8'h01);
    @(posedge mclk_in) ring_detect_signal_in <= 1'b1;
    wr(`STAT_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h20);
    n = irqs;
    @(posedge mclk_in) ring_detect_signal_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h00);
    fe.set_line(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge mclk_in);
    check(took(), 8'h01);
    rd(`STAT_ADDR, d); check(d & 8'h09, 8'h09);
    @(posedge mclk_in) ring_detect_signal_in <= 1'b1;
    @(posedge mclk_in) sys_rst_in <= 1'b1;
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(`CTRL_ADDR, d); check(d, 8'h0f);
    rd(`STAT_ADDR, d); check(d, 8'h30);
    rd(`BYTE_ADDR, d); check(d, 8'h00);
    summarize();
  end
endmodule : fsk_serial_packet_decoder_test
`default_nettype wire
